// ===== rtl/actr_pkg.sv
// Constants, field layouts and carrier types of the channel trim register bank.
// Assumes a control-port engine that turns bus frames into single register accesses.
// Notes on behaviour
// (R1) Gain: six bits 7-2, 0..42 dB
// (R2) Volume code zero mutes the channel
// (R3) Volume 0.5 dB steps, 201 is unity
// (R4) Volume register at 0x3E, reset 0xC9
// (R5) Trim bits 7-4, 0.1 dB, 8 is 0 dB
// (R6) Trim register 0x3F, reset 0x80, low zero
// (R7) Phase delay in whole modulator clock periods
// (R8) Delay code counts modulator cycles, 0..255
// (R9) Phase delay register 0x40, reset zero
// (R10) Channel 2 input config 0x41, fields, reset
// (R11) Source: differential, single-ended, pulse density
// (R12) Type mic/line; auto level bit enables
// (R13) Host avoids reserved codes, writes zeros
package actr_pkg;

  localparam int  DATA_W = 8;
  localparam int  ADDR_W = 8;
  localparam int  SAMP_W = 24;
  localparam int  DLY_W  = 8;

  localparam logic [7:0] PAGE_MAIN = 8'h00;

  // Register offsets on page 0
  localparam logic [ADDR_W-1:0] OFS_ANALOG_GAIN  = 8'h3d;
  localparam logic [ADDR_W-1:0] OFS_DIG_VOLUME   = 8'h3e;
  localparam logic [ADDR_W-1:0] OFS_GAIN_TRIM    = 8'h3f;
  localparam logic [ADDR_W-1:0] OFS_PHASE_DELAY  = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_CH2_INPUT    = 8'h41;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ANALOG_GAIN  = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIG_VOLUME   = 8'hc9;
  localparam logic [DATA_W-1:0] RST_GAIN_TRIM    = 8'h80;
  localparam logic [DATA_W-1:0] RST_PHASE_DELAY  = 8'h00;
  localparam logic [DATA_W-1:0] RST_CH2_INPUT    = 8'h00;
  localparam logic [DATA_W-1:0] RD_UNMAPPED      = 8'h00;

  // Writable bit masks; reserved bits stay zero
  localparam logic [DATA_W-1:0] MASK_ANALOG_GAIN = 8'hfc;
  localparam logic [DATA_W-1:0] MASK_GAIN_TRIM   = 8'hf0;
  localparam logic [DATA_W-1:0] MASK_CH2_INPUT   = 8'hfd;
  localparam logic [DATA_W-1:0] MASK_FULL        = 8'hff;

  // Field positions
  localparam int  GAIN_LSB   = 2;
  localparam int  TRIM_LSB   = 4;
  localparam int  KIND_BIT   = 7;
  localparam int  SRC_LSB    = 5;
  localparam int  COUPLE_BIT = 4;
  localparam int  IMP_LSB    = 2;
  localparam int  AUTO_BIT   = 0;

  // Code figures
  localparam logic [5:0] GAIN_MAX_CODE  = 6'h2a;
  localparam logic [7:0] VOL_MUTE_CODE  = 8'h00;
  localparam logic [7:0] VOL_UNITY_CODE = 8'hc9;
  localparam logic [3:0] TRIM_ZERO_CODE = 4'h8;

  typedef enum logic [1:0] {
    ACTR_SRC_DIFF   = 2'h0,
    ACTR_SRC_SINGLE = 2'h1,
    ACTR_SRC_PDM    = 2'h2,
    ACTR_SRC_RSVD   = 2'h3
  } actr_src_t;

  typedef struct packed {
    logic [5:0]       code_a;
    logic             gain_reserved;
    logic [7:0]       ch1_volume_code;
    logic             mute;
    logic signed [8:0] vol_half_db;
    logic [3:0]       ch1_trim_code;
    logic signed [4:0] trim_tenth_db;
    logic [7:0]       ch1_delay_code;
  } actr_ch1_cfg_t;

  typedef struct packed {
    logic       ch2_input_kind;
    actr_src_t  ch2_input_source;
    logic       ch2_coupling_select;
    logic [1:0] ch2_impedance_select;
    logic       ch2_auto_level_on;
    logic       pulse_density_input;
    logic       src_reserved;
  } actr_ch2_cfg_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [7:0]        page;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } actr_req_t;

endpackage

// ===== rtl/actr_phase_delay.sv
// Phase delay line for one channel's modulator bit stream.
// Assumes mod_tick is a one-cycle enable at the modulator rate.
`timescale 1ns/10ps
module actr_phase_delay
  import actr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Stream
  input  wire logic             mod_tick,
  input  wire logic             bit_in,
  input  wire logic [DLY_W-1:0] delay_code,
  output logic                  bit_out
);

  localparam int DEPTH = 1 << DLY_W;

  logic [DEPTH-1:0] hist_reg;
  logic [DLY_W-1:0] wptr_reg;
  logic [DLY_W-1:0] rd_idx;

  // Entry written delay_code ticks ago
  assign rd_idx = wptr_reg - delay_code;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hist_reg <= '0;
      wptr_reg <= '0;
    end else if (mod_tick) begin
      hist_reg[wptr_reg] <= bit_in;
      wptr_reg           <= wptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_out <= 1'b0;
    end else if (mod_tick) begin
      bit_out <= (delay_code == '0) ? bit_in : hist_reg[rd_idx]; // see (R7) (R8)
    end
  end

  a_delay_zero_pass: assert property (@(posedge clk) disable iff (rst) // see (R8)
    mod_tick && delay_code == '0 |=> bit_out == $past(bit_in))
    else $error("zero delay does not pass the bit through");

  a_delay_one_tick: assert property (@(posedge clk) disable iff (rst) // see (R7)
    mod_tick && delay_code == 8'h01 ##1 (!mod_tick && delay_code == 8'h01) [*1] ##1
    (mod_tick && delay_code == 8'h01)
    |=> bit_out == $past(bit_in, 3))
    else $error("one-cycle delay does not return the previous bit");

endmodule

// ===== rtl/actr_regs.sv
// Channel trim and input configuration register bank with channel 1 signal controls.
// Assumes one access per cycle from the control-port engine; page held by that engine.
`timescale 1ns/10ps
module actr_regs
  import actr_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register access
  input  wire actr_req_t         req,
  output logic [DATA_W-1:0]      rdata,
  output logic                   rvalid,
  // Channel 1 sample path
  input  wire logic              samp_in_valid,
  input  wire logic [SAMP_W-1:0] samp_in_data,
  output logic                   samp_out_valid,
  output logic [SAMP_W-1:0]      samp_out_data,
  // Channel 1 modulator stream
  input  wire logic              mod_tick,
  input  wire logic              mod_bit_in,
  output logic                   mod_bit_out,
  // Decoded settings
  output actr_ch1_cfg_t          ch1_cfg,
  output actr_ch2_cfg_t          ch2_cfg
);

  logic [DATA_W-1:0] ch1_analog_gain_reg;
  logic [DATA_W-1:0] ch1_digital_volume_reg;
  logic [DATA_W-1:0] code_a_trim_reg;
  logic [DATA_W-1:0] ch1_phase_delay_reg;
  logic [DATA_W-1:0] ch2_input_config_reg;
  logic              page_hit;
  logic [DATA_W-1:0] rd_mux;

  function automatic logic hit(input actr_req_t r, input logic [ADDR_W-1:0] ofs);
    hit = (r.page == PAGE_MAIN) && (r.addr == ofs);
  endfunction

  assign page_hit = req.page == PAGE_MAIN;

  // Register writes, reserved bits forced low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1_analog_gain_reg <= RST_ANALOG_GAIN;
    end else if (req.wr && hit(req, OFS_ANALOG_GAIN)) begin
      ch1_analog_gain_reg <= req.wdata & MASK_ANALOG_GAIN; // see (R1)
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1_digital_volume_reg <= RST_DIG_VOLUME; // see (R4)
    end else if (req.wr && hit(req, OFS_DIG_VOLUME)) begin
      ch1_digital_volume_reg <= req.wdata & MASK_FULL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_a_trim_reg <= RST_GAIN_TRIM; // see (R6)
    end else if (req.wr && hit(req, OFS_GAIN_TRIM)) begin
      code_a_trim_reg <= req.wdata & MASK_GAIN_TRIM; // see (R6)
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch1_phase_delay_reg <= RST_PHASE_DELAY; // see (R9)
    end else if (req.wr && hit(req, OFS_PHASE_DELAY)) begin
      ch1_phase_delay_reg <= req.wdata & MASK_FULL;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ch2_input_config_reg <= RST_CH2_INPUT; // see (R10)
    end else if (req.wr && hit(req, OFS_CH2_INPUT)) begin
      ch2_input_config_reg <= req.wdata & MASK_CH2_INPUT; // see (R10)
    end
  end

  // Read path
  always_comb begin
    rd_mux = RD_UNMAPPED;
    if (page_hit) begin
      unique case (req.addr)
        OFS_ANALOG_GAIN: rd_mux = ch1_analog_gain_reg;
        OFS_DIG_VOLUME:  rd_mux = ch1_digital_volume_reg;
        OFS_GAIN_TRIM:   rd_mux = code_a_trim_reg;
        OFS_PHASE_DELAY: rd_mux = ch1_phase_delay_reg;
        OFS_CH2_INPUT:   rd_mux = ch2_input_config_reg;
        default:         rd_mux = RD_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata  <= RD_UNMAPPED;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rd_mux;
      end
    end
  end

  // Channel 1 decoded settings
  always_comb begin
    ch1_cfg.code_a          = ch1_analog_gain_reg[GAIN_LSB +: 6]; // see (R1)
    ch1_cfg.gain_reserved   = ch1_cfg.code_a > GAIN_MAX_CODE; // see (R1)
    ch1_cfg.ch1_volume_code = ch1_digital_volume_reg;
    ch1_cfg.mute            = ch1_digital_volume_reg == VOL_MUTE_CODE; // see (R2)
    // Half-dB steps around unity code
    ch1_cfg.vol_half_db     = $signed({1'b0, ch1_digital_volume_reg})
                              - $signed({1'b0, VOL_UNITY_CODE}); // see (R3)
    ch1_cfg.ch1_trim_code   = code_a_trim_reg[TRIM_LSB +: 4]; // see (R5)
    ch1_cfg.trim_tenth_db   = $signed({1'b0, ch1_cfg.ch1_trim_code})
                              - $signed({1'b0, TRIM_ZERO_CODE}); // see (R5)
    ch1_cfg.ch1_delay_code  = ch1_phase_delay_reg; // see (R8)
  end

  // Channel 2 decoded settings
  always_comb begin
    ch2_cfg.ch2_input_kind       = ch2_input_config_reg[KIND_BIT]; // see (R12)
    ch2_cfg.ch2_input_source     = actr_src_t'(ch2_input_config_reg[SRC_LSB +: 2]); // see (R11)
    ch2_cfg.ch2_coupling_select  = ch2_input_config_reg[COUPLE_BIT];
    ch2_cfg.ch2_impedance_select = ch2_input_config_reg[IMP_LSB +: 2];
    ch2_cfg.ch2_auto_level_on    = ch2_input_config_reg[AUTO_BIT]; // see (R12)
    ch2_cfg.pulse_density_input  = ch2_cfg.ch2_input_source == ACTR_SRC_PDM; // see (R11)
    ch2_cfg.src_reserved         = ch2_cfg.ch2_input_source == ACTR_SRC_RSVD;
  end

  // Sample path: mute replaces samples with zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      samp_out_valid <= 1'b0;
      samp_out_data  <= '0;
    end else begin
      samp_out_valid <= samp_in_valid;
      if (samp_in_valid) begin
        samp_out_data <= ch1_cfg.mute ? '0 : samp_in_data; // see (R2)
      end
    end
  end

  actr_phase_delay u_delay (
    .clk        (clk),
    .rst        (rst),
    .mod_tick   (mod_tick),
    .bit_in     (mod_bit_in),
    .delay_code (ch1_phase_delay_reg),
    .bit_out    (mod_bit_out)
  );

  a_mute_zero_out: assert property (@(posedge clk) disable iff (rst) // see (R2)
    samp_in_valid && ch1_digital_volume_reg == VOL_MUTE_CODE |=> samp_out_data == '0)
    else $error("muted channel passed a nonzero sample");

  a_pass_unmuted: assert property (@(posedge clk) disable iff (rst) // see (R3)
    samp_in_valid && ch1_digital_volume_reg != VOL_MUTE_CODE
    |=> samp_out_data == $past(samp_in_data))
    else $error("unmuted sample was altered");

  a_vol_unity: assert property (@(posedge clk) disable iff (rst) // see (R3)
    ch1_digital_volume_reg == VOL_UNITY_CODE |-> ch1_cfg.vol_half_db == 9'sd0)
    else $error("unity code does not give zero half-dB");

  a_vol_write_rb: assert property (@(posedge clk) disable iff (rst) // see (R4)
    req.wr && hit(req, OFS_DIG_VOLUME) ##1 !req.wr ##1
    (req.rd && hit(req, OFS_DIG_VOLUME) && !req.wr)
    |=> rvalid && rdata == $past(req.wdata, 3))
    else $error("volume register read-back mismatch");

  a_trim_low_zero: assert property (@(posedge clk) disable iff (rst) // see (R6)
    code_a_trim_reg[TRIM_LSB-1:0] == '0 && ch1_cfg.trim_tenth_db ==
    $signed({1'b0, code_a_trim_reg[7:4]}) - 5'sd8)
    else $error("gain trim reserved bits set or trim offset wrong");

  a_gain_reserved: assert property (@(posedge clk) disable iff (rst) // see (R1)
    ch1_cfg.gain_reserved == (ch1_analog_gain_reg[7:2] > 6'd42)
    && ch1_analog_gain_reg[1:0] == '0)
    else $error("analog gain reserved flag or low bits wrong");

  a_ch2_rsvd_bit: assert property (@(posedge clk) disable iff (rst) // see (R10)
    req.wr && hit(req, OFS_CH2_INPUT) |=> ch2_input_config_reg[1] == 1'b0
    && ch2_input_config_reg[0] == $past(req.wdata[0]))
    else $error("input config reserved bit or auto level bit wrong");

  a_pdm_select: assert property (@(posedge clk) disable iff (rst) // see (R11)
    ch2_cfg.pulse_density_input == (ch2_input_config_reg[6:5] == 2'h2))
    else $error("pulse density select decode wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (rst) // see (R9)
    req.rd && req.page != PAGE_MAIN |=> rvalid && rdata == '0)
    else $error("unmapped read not zero");

  c_mute_sample: cover property (@(posedge clk) disable iff (rst)
    samp_in_valid && ch1_cfg.mute);
  c_delay_max: cover property (@(posedge clk) disable iff (rst)
    mod_tick && ch1_phase_delay_reg == 8'hff);
  c_pdm_source: cover property (@(posedge clk) disable iff (rst)
    ch2_cfg.pulse_density_input && ch2_cfg.ch2_auto_level_on);

endmodule

// ===== dv/actr_host_model.sv
// Host model issuing single register accesses on the control port.
// Assumes the bank answers a read with rvalid exactly one cycle later.
`timescale 1ns/10ps
module actr_host_model
  import actr_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Register access
  output actr_req_t              req,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rvalid
);
  initial req = '0;
  // Request held one cycle; answer taken after the following edge
  task automatic access(input logic w, input logic [7:0] pg, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clk);
    #1;
    req = '{wr: w, rd: !w, page: pg, addr: a, wdata: d};
    @(posedge clk);
    #1;
    req = '0;
    q = rdata;
    v = rvalid;
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the channel trim register bank.
// Assumes the host model as the only register bus master.
`timescale 1ns/10ps
module tb_top
  import actr_pkg::*;
;
  logic               clk;
  logic               rst;
  actr_req_t          req;
  logic [DATA_W-1:0]  rdata;
  logic               rvalid;
  logic               samp_in_valid;
  logic [SAMP_W-1:0]  samp_in_data;
  logic               samp_out_valid;
  logic [SAMP_W-1:0]  samp_out_data;
  logic               mod_tick;
  logic               mod_bit_in;
  logic               mod_bit_out;
  actr_ch1_cfg_t      ch1_cfg;
  actr_ch2_cfg_t      ch2_cfg;
  int                 n_mismatch;
  int                 checked;

  actr_regs actr_regs_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .samp_in_valid(samp_in_valid), .samp_in_data(samp_in_data),
    .samp_out_valid(samp_out_valid), .samp_out_data(samp_out_data),
    .mod_tick(mod_tick), .mod_bit_in(mod_bit_in), .mod_bit_out(mod_bit_out),
    .ch1_cfg(ch1_cfg), .ch2_cfg(ch2_cfg));
  actr_host_model actr_host_model_inst (.clk(clk), .req(req), .rdata(rdata),
    .rvalid(rvalid));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       v;
    actr_host_model_inst.access(1'b1, pg, a, d, q, v);
  endtask

  task automatic rd_chk(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic       v;
    actr_host_model_inst.access(1'b0, pg, a, 8'h00, q, v);
    check("rvalid", v, 1);
    check($sformatf("reg %0h", a), q, e);
  endtask

  task automatic samp(input logic [23:0] d, input logic [23:0] e);
    @(posedge clk);
    #1;
    samp_in_valid = 1'b1;
    samp_in_data = d;
    @(posedge clk);
    #1;
    samp_in_valid = 1'b0;
    check("samp_out_valid", samp_out_valid, 1);
    check("samp_out_data", samp_out_data, e);
  endtask

  function automatic logic pat(input int i);
    return i[0] ^ i[2] ^ i[5];
  endfunction

  task automatic t_reset();
    logic [7:0] ofs[5] = '{8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41};
    logic [7:0] rv[5]  = '{8'h00, 8'hc9, 8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'h00, ofs[i], rv[i]);
    end
    check("vol_half_db", $unsigned(ch1_cfg.vol_half_db), 9'h000);
    check("trim_tenth_db", $unsigned(ch1_cfg.trim_tenth_db), 5'h00);
    $display("test reset done");
  endtask

  task automatic t_gain();
    wr(8'h00, 8'h3d, 8'hab);
    rd_chk(8'h00, 8'h3d, 8'ha8);
    check("code_a", ch1_cfg.code_a, 6'h2a);
    check("gain_reserved", ch1_cfg.gain_reserved, 0);
    wr(8'h00, 8'h3d, 8'hac);
    check("gain_reserved", ch1_cfg.gain_reserved, 1);
    $display("test gain done");
  endtask

  task automatic t_volume();
    wr(8'h00, 8'h3e, 8'h00);
    check("mute", ch1_cfg.mute, 1);
    samp(24'h123456, 24'h000000);
    wr(8'h00, 8'h3e, 8'h01);
    check("mute", ch1_cfg.mute, 0);
    check("vol_half_db", $unsigned(ch1_cfg.vol_half_db), 9'h138);
    wr(8'h00, 8'h3e, 8'hff);
    check("vol_code", ch1_cfg.ch1_volume_code, 8'hff);
    check("vol_half_db", $unsigned(ch1_cfg.vol_half_db), 9'h036);
    rd_chk(8'h00, 8'h3e, 8'hff);
    wr(8'h00, 8'h3e, 8'hc9);
    check("vol_half_db", $unsigned(ch1_cfg.vol_half_db), 9'h000);
    samp(24'habcdef, 24'habcdef);
    wr(8'h01, 8'h3e, 8'h55);
    rd_chk(8'h01, 8'h3e, 8'h00);
    rd_chk(8'h00, 8'h3e, 8'hc9);
    rd_chk(8'h00, 8'h42, 8'h00);
    $display("test volume done");
  endtask

  task automatic t_trim();
    wr(8'h00, 8'h3f, 8'hff);
    rd_chk(8'h00, 8'h3f, 8'hf0);
    check("trim_code", ch1_cfg.ch1_trim_code, 4'hf);
    check("trim_tenth_db", $unsigned(ch1_cfg.trim_tenth_db), 5'h07);
    wr(8'h00, 8'h3f, 8'h00);
    check("trim_tenth_db", $unsigned(ch1_cfg.trim_tenth_db), 5'h18);
    $display("test trim done");
  endtask

  task automatic t_delay(input logic [7:0] code);
    wr(8'h00, 8'h40, code);
    rd_chk(8'h00, 8'h40, code);
    check("delay_code", ch1_cfg.ch1_delay_code, code);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      mod_tick = 1'b1;
      mod_bit_in = pat(i);
      @(posedge clk);
      #1;
      mod_tick = 1'b0;
      if (i >= code) begin
        check("mod_bit_out", mod_bit_out, pat(i - code));
      end
    end
    $display("test delay %0d done", code);
  endtask

  task automatic t_ch2();
    logic [7:0] d;
    for (int s = 0; s < 4; s++) begin
      d = {s[0], s[1:0], s[1], s[1:0], 1'b1, !s[0]};
      wr(8'h00, 8'h41, d);
      rd_chk(8'h00, 8'h41, d & 8'hfd);
      check("source", ch2_cfg.ch2_input_source, s[1:0]);
      check("pdm", ch2_cfg.pulse_density_input, s == 2);
      check("src_rsvd", ch2_cfg.src_reserved, s == 3);
      check("kind", ch2_cfg.ch2_input_kind, s[0]);
      check("auto", ch2_cfg.ch2_auto_level_on, !s[0]);
      check("couple", ch2_cfg.ch2_coupling_select, s[1]);
      check("imp", ch2_cfg.ch2_impedance_select, s[1:0]);
    end
    $display("test ch2 done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    samp_in_valid = 1'b0;
    samp_in_data = '0;
    mod_tick = 1'b0;
    mod_bit_in = 1'b0;
    n_mismatch = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_gain();
    t_volume();
    t_trim();
    t_delay(8'h00);
    t_delay(8'h01);
    t_delay(8'h03);
    t_delay(8'hff);
    t_ch2();
    stop_test();
  end
endmodule
